// ---- hdl/adcsc_pkg.sv ----
/*
 * constants shared by the conversion sequence control block:
 * register offsets, field positions, reset values and cycle counts.
 * assumes an 8-bit register port and a 250 MHz clock.
 */
`default_nettype none
package adcsc_pkg;
	// ******************************
	// register offsets
	// ******************************
	localparam logic [7:0] ADDR_CTL2   = 8'h02;
	localparam logic [7:0] ADDR_CFLAG  = 8'h08;
	localparam logic [7:0] ADDR_CMPEN  = 8'h09;
	localparam logic [7:0] ADDR_TSRC   = 8'h0A;
	localparam logic [7:0] ADDR_ISTAT  = 8'h0B;
	localparam logic [7:0] ADDR_IMASK  = 8'h0C;
	localparam logic [7:0] ADDR_STATE  = 8'h0D;
	localparam logic [7:0] ADDR_START  = 8'h0E;
	localparam logic [4:0] RES_BASE_HI = 5'h02;
	// ******************************
	// field positions
	// ******************************
	localparam int BIT_FAST_CLEAR  = 6;
	localparam int BIT_STOP_ICLOCK = 5;
	localparam int BIT_LEVEL_EDGE  = 4;
	localparam int BIT_POLARITY    = 3;
	localparam int BIT_TRIG_ENABLE = 2;
	localparam int BIT_SRC_ANALOG  = 3;
	localparam int BIT_IST_SEQ     = 0;
	localparam int BIT_IST_CMP     = 1;
	localparam logic [7:0] CTL2_MASK = 8'h7C;
	// ******************************
	// reset values
	// ******************************
	localparam logic [7:0] RST_CTL2  = 8'h00;
	localparam logic [7:0] RST_CFLAG = 8'h00;
	localparam logic [7:0] RST_CMPEN = 8'h00;
	localparam logic [3:0] RST_TSRC  = 4'h0;
	localparam logic [1:0] RST_IST   = 2'h0;
	localparam logic [1:0] RST_IMASK = 2'h0;
	// ******************************
	// timing
	// ******************************
	localparam int CLK_MHZ         = 250;
	localparam int ICLOCK_NS       = 32;
	localparam int ICLOCK_DIV      = (ICLOCK_NS * CLK_MHZ) / 1000;
	localparam logic [2:0] CONV_TICKS = 3'h4;
	localparam logic [2:0] SEQ_LAST   = 3'h7;
	// ******************************
	// sequencer states
	// ******************************
	typedef enum logic [1:0] {S_IDLE, S_CONV, S_SUSP} adcsc_state_e;
endpackage
`default_nettype wire

// ---- hdl/adcsc_top.sv ----
/*
 * conversion sequence control: control register two, completion flags,
 * stop-mode clock switch, external trigger qualification and interrupt.
 * assumes a plain register port with read data one cycle after the strobe,
 * and that the result registers sit elsewhere, decoded here only for access.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - any control write aborts running sequence
// - no fast clear: write one clears flag
// - fast clear, compare off: result read clears
// - fast clear, compare on: result write clears
// - stop with clock bit: internal clock, continue
// - prescaler never affects internal clock rate
// - interrupts still signal during stop conversions
// - external trigger ignored on stop-mode clock
// - transition-spanning conversion: no result, flag, compare
// - trigger enable bit arms selected trigger source
// - analog trigger source enables its input buffer while the trigger enable bit is set
// - bit four selects level or edge
// - bit three selects trigger polarity
module adcsc_top
	import adcsc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	input  wire logic       stop_mode,
	input  wire logic [4:0] prescaler_select,
	input  wire logic [3:0] dedicated_trigger_inputs,
	input  wire logic [7:0] ain_digital,
	input  wire logic       compare_hit,
	output var  logic [7:0] conversion_complete_flag,
	output var  logic       result_write,
	output var  logic [2:0] result_channel,
	output var  logic       compare_strobe,
	output var  logic [7:0] digital_input_enable,
	output var  logic       conversion_active,
	output var  logic       irq
);
	// ******************************
	// decode
	// ******************************
	function automatic logic is_result(input logic [7:0] a);
		is_result = (a[7:3] == RES_BASE_HI);
	endfunction

	logic [7:0]   ctl_ff;
	logic [7:0]   cflag_ff;
	logic [7:0]   cmpen_ff;
	logic [3:0]   tsrc_ff;
	logic [1:0]   ist_ff;
	logic [1:0]   imask_ff;
	adcsc_state_e state_ff;
	adcsc_state_e nxt_state;
	logic [2:0]   cnt_ff;
	logic [2:0]   nxt_cnt;
	logic [2:0]   chan_ff;
	logic [2:0]   nxt_chan;
	logic         span_ff;
	logic         nxt_span;
	logic         stop_q_ff;
	logic         act_q_ff;
	logic [5:0]   prs_cnt_ff;
	logic [7:0]   icnt_ff;

	wire ctl_wr   = wr && (addr == ADDR_CTL2);
	wire flag_wr  = wr && (addr == ADDR_CFLAG);
	wire start_wr = wr && (addr == ADDR_START) && wdata[0];
	wire res_rd   = rd && is_result(addr);
	wire res_wr   = wr && is_result(addr);
	wire fast_clr = ctl_ff[BIT_FAST_CLEAR];

	// ******************************
	// conversion clock select
	// ******************************
	wire [5:0] prs_lim  = {prescaler_select, 1'b1};
	wire       bus_tick = (prs_cnt_ff == prs_lim);
	wire       int_tick = (icnt_ff == 8'(ICLOCK_DIV - 1));
	wire       use_int  = stop_mode && ctl_ff[BIT_STOP_ICLOCK];
	wire       freeze   = stop_mode && !ctl_ff[BIT_STOP_ICLOCK];
	wire       tick     = use_int ? int_tick : (!stop_mode && bus_tick);
	wire       stop_chg = (stop_mode != stop_q_ff);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prs_cnt_ff <= 6'h00;
			icnt_ff    <= 8'h00;
		end else begin
			prs_cnt_ff <= bus_tick ? 6'h00 : prs_cnt_ff + 6'h01;
			icnt_ff    <= int_tick ? 8'h00 : icnt_ff + 8'h01;
		end
	end

	// ******************************
	// external trigger
	// ******************************
	wire trig_src = tsrc_ff[BIT_SRC_ANALOG] ? ain_digital[tsrc_ff[2:0]]
		: dedicated_trigger_inputs[tsrc_ff[1:0]];
	wire trig_act = ctl_ff[BIT_POLARITY] ? trig_src : !trig_src;
	wire trig_hit = ctl_ff[BIT_LEVEL_EDGE] ? trig_act : (trig_act && !act_q_ff);
	wire trig_arm = ctl_ff[BIT_TRIG_ENABLE] && !use_int;
	wire trig_go  = trig_arm && trig_hit && !freeze;
	wire [7:0] dib_sel = (ctl_ff[BIT_TRIG_ENABLE] && tsrc_ff[BIT_SRC_ANALOG])
		? (8'h01 << tsrc_ff[2:0]) : 8'h00;

	// ******************************
	// sequencer
	// ******************************
	wire conv_end = (state_ff == S_CONV) && !ctl_wr && !freeze && tick && (cnt_ff == CONV_TICKS - 3'h1);
	wire conv_ok  = conv_end && !span_ff && !stop_chg;
	wire seq_end  = conv_end && (chan_ff == SEQ_LAST);
	wire cmp_do   = conv_ok && cmpen_ff[chan_ff];
	wire cmp_ev   = cmp_do && compare_hit;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_chan  = chan_ff;
		nxt_span  = span_ff;
		case (state_ff)
			S_IDLE: begin
				if ((start_wr || trig_go) && !ctl_wr && !freeze) begin
					nxt_state = S_CONV;
					nxt_cnt   = 3'h0;
					nxt_chan  = 3'h0;
					nxt_span  = 1'b0;
				end
			end
			S_CONV: begin
				if (ctl_wr) begin
					nxt_state = S_IDLE;
				end else if (freeze) begin
					nxt_state = S_SUSP;
				end else begin
					if (stop_chg) begin
						nxt_span = 1'b1;
					end
					if (tick) begin
						if (conv_end) begin
							nxt_cnt  = 3'h0;
							nxt_span = 1'b0;
							nxt_chan = chan_ff + 3'h1;
							if (seq_end) begin
								nxt_state = S_IDLE;
							end
						end else begin
							nxt_cnt = cnt_ff + 3'h1;
						end
					end
				end
			end
			S_SUSP: begin
				if (ctl_wr) begin
					nxt_state = S_IDLE;
				end else if (!stop_mode) begin
					nxt_state = S_CONV;
					nxt_cnt   = 3'h0;
					nxt_chan  = 3'h0;
					nxt_span  = 1'b0;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= S_IDLE;
			cnt_ff    <= 3'h0;
			chan_ff   <= 3'h0;
			span_ff   <= 1'b0;
			stop_q_ff <= 1'b0;
			act_q_ff  <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			chan_ff   <= nxt_chan;
			span_ff   <= nxt_span;
			stop_q_ff <= stop_mode;
			act_q_ff  <= trig_act;
		end
	end

	// ******************************
	// completion flags
	// ******************************
	wire  [7:0] nxt_cflag;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			wire set_f = conv_ok && (chan_ff == 3'(gi));
			wire hit_n = (addr[2:0] == 3'(gi));
			wire w1c   = !fast_clr && flag_wr && wdata[gi];
			wire rdclr = fast_clr && res_rd && hit_n && !cmpen_ff[gi];
			wire wrclr = fast_clr && res_wr && hit_n && cmpen_ff[gi];
			assign nxt_cflag[gi] = set_f || (cflag_ff[gi] && !(w1c || rdclr || wrclr));
		end
	endgenerate

	// ******************************
	// interrupt status
	// ******************************
	wire [1:0] ist_set  = {cmp_ev, seq_end};
	wire [1:0] ist_clr  = (wr && addr == ADDR_ISTAT) ? wdata[1:0] : 2'h0;
	wire [1:0] nxt_ist  = ist_set | (ist_ff & ~ist_clr);
	wire [1:0] nxt_mask = (wr && addr == ADDR_IMASK) ? wdata[1:0] : imask_ff;

	// ******************************
	// registers
	// ******************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctl_ff   <= RST_CTL2;
			cmpen_ff <= RST_CMPEN;
			tsrc_ff  <= RST_TSRC;
		end else begin
			if (ctl_wr) begin
				ctl_ff <= wdata & CTL2_MASK;
			end
			if (wr && addr == ADDR_CMPEN) begin
				cmpen_ff <= wdata;
			end
			if (wr && addr == ADDR_TSRC) begin
				tsrc_ff <= wdata[3:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cflag_ff <= RST_CFLAG;
			ist_ff   <= RST_IST;
			imask_ff <= RST_IMASK;
		end else begin
			cflag_ff <= nxt_cflag;
			ist_ff   <= nxt_ist;
			imask_ff <= nxt_mask;
		end
	end

	// ******************************
	// read mux
	// ******************************
	logic [7:0] rmux;
	always_comb begin
		case (addr)
			ADDR_CTL2:  rmux = ctl_ff;
			ADDR_CFLAG: rmux = cflag_ff;
			ADDR_CMPEN: rmux = cmpen_ff;
			ADDR_TSRC:  rmux = {4'h0, tsrc_ff};
			ADDR_ISTAT: rmux = {6'h00, ist_ff};
			ADDR_IMASK: rmux = {6'h00, imask_ff};
			ADDR_STATE: rmux = {5'h00, use_int, state_ff == S_SUSP, state_ff != S_IDLE};
			default:    rmux = 8'h00;
		endcase
	end

	// ******************************
	// outputs
	// ******************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata                    <= 8'h00;
			conversion_complete_flag <= 8'h00;
			result_write             <= 1'b0;
			result_channel           <= 3'h0;
			compare_strobe           <= 1'b0;
			digital_input_enable     <= 8'h00;
			conversion_active        <= 1'b0;
			irq                      <= 1'b0;
		end else begin
			rdata                    <= rd ? rmux : 8'h00;
			conversion_complete_flag <= nxt_cflag;
			result_write             <= conv_ok;
			result_channel           <= chan_ff;
			compare_strobe           <= cmp_do;
			digital_input_enable     <= dib_sel;
			conversion_active        <= (nxt_state == S_CONV);
			irq                      <= |(nxt_ist & nxt_mask);
		end
	end
endmodule // adcsc_top
`default_nettype wire

// ---- dv/adcsc_monitor.sv ----
/* checker for the conversion sequence control block ports.
 * assumes the package register map and the single clock mclk. */
`timescale 1ns/1ps
`default_nettype none
module adcsc_monitor
	import adcsc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic       stop_mode,
	input wire logic [7:0] conversion_complete_flag,
	input wire logic       result_write,
	input wire logic [2:0] result_channel,
	input wire logic       compare_strobe,
	input wire logic       conversion_active
);
	// ******************************
	// properties
	// ******************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic       fast_ff;
	logic [7:0] cmp_ff;
	wire        res_hit = addr[7:3] == RES_BASE_HI;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fast_ff <= 1'b0;
			cmp_ff  <= 8'h00;
		end else if (wr && addr == ADDR_CTL2) begin
			fast_ff <= wdata[BIT_FAST_CLEAR];
		end else if (wr && addr == ADDR_CMPEN) begin
			cmp_ff <= wdata;
		end
	end
	AST_ABORT: assert property (wr && addr == ADDR_CTL2 |=> !conversion_active && !result_write)
		else $error("control write did not abort");
	AST_W1C: assert property (wr && addr == ADDR_CFLAG && !fast_ff
		|=> result_write || (conversion_complete_flag & $past(wdata)) == 8'h00)
		else $error("flag not cleared by write one");
	AST_W1C_IGN: assert property (wr && addr == ADDR_CFLAG && fast_ff
		|=> (conversion_complete_flag & $past(conversion_complete_flag)) == $past(conversion_complete_flag))
		else $error("flag write not ignored in fast clear");
	AST_FAST_RD: assert property (rd && res_hit && fast_ff && !cmp_ff[addr[2:0]]
		|=> result_write || !conversion_complete_flag[$past(addr[2:0])])
		else $error("result read did not clear flag");
	AST_FAST_WR: assert property (wr && res_hit && fast_ff && cmp_ff[addr[2:0]]
		|=> result_write || !conversion_complete_flag[$past(addr[2:0])])
		else $error("result write did not clear flag");
	AST_STOP_DISCARD: assert property ($changed(stop_mode) |=> !result_write)
		else $error("result stored across stop change");
	AST_FLAG_SET: assert property (result_write |-> conversion_complete_flag[result_channel])
		else $error("stored result without flag");
	AST_CMP_PAIR: assert property (compare_strobe |-> result_write)
		else $error("compare without stored result");
endmodule // adcsc_monitor
bind adcsc_top adcsc_monitor i_adcsc_monitor (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .stop_mode(stop_mode), .conversion_complete_flag(conversion_complete_flag),
	.result_write(result_write), .result_channel(result_channel), .compare_strobe(compare_strobe),
	.conversion_active(conversion_active));
`default_nettype wire

// ---- dv/adcsc_far.sv ----
/* far side: trigger pins, analog channel levels and compare logic.
 * assumes the bench sets the wanted levels; they appear one edge later. */
`timescale 1ns/1ps
`default_nettype none
module adcsc_far (
	input  wire logic       mclk,
	input  wire logic [3:0] trig_set,
	input  wire logic [7:0] ain_set,
	input  wire logic       hit_set,
	output var  logic [3:0] trig_out,
	output var  logic [7:0] ain_out,
	output var  logic       hit_out
);
	// ******************************
	// sources
	// ******************************
	always_ff @(posedge mclk) begin
		trig_out <= trig_set;
		ain_out  <= ain_set;
		hit_out  <= hit_set;
	end
endmodule // adcsc_far
`default_nettype wire

// ---- dv/tb.sv ----
/* self-checking bench for the conversion sequence control block.
 * assumes the package map and bus ticks every two clocks at prescaler zero. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import adcsc_pkg::*;
;
	// ******************************
	// bench
	// ******************************
	logic       mclk, resetn, wr, rd, stop_mode, hit, hit_io, result_write, act, irq;
	logic [7:0] addr, wdata, ain, ain_io, rdata, die;
	logic [4:0] psel;
	logic [3:0] trig, trig_io;
	int         n_fail, samples_checked, k;
	adcsc_far i_adcsc_far (.mclk(mclk), .trig_set(trig), .ain_set(ain), .hit_set(hit), .trig_out(trig_io),
		.ain_out(ain_io), .hit_out(hit_io));
	adcsc_top i_adcsc_top (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .stop_mode(stop_mode), .prescaler_select(psel), .dedicated_trigger_inputs(trig_io),
		.ain_digital(ain_io), .compare_hit(hit_io), .conversion_complete_flag(), .result_write(result_write),
		.result_channel(), .compare_strobe(), .digital_input_enable(die), .conversion_active(act), .irq(irq));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (6000) @(posedge mclk);
		n_fail++;
		close_out;
	end
	initial begin
		{resetn, wr, rd, stop_mode, hit, addr, wdata, ain, psel, trig, n_fail, samples_checked} = '0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rchk(ADDR_CTL2, RST_CTL2);
		rchk(8'h30, 8'h00);
		wreg(ADDR_CTL2, 8'hFF);
		rchk(ADDR_CTL2, CTL2_MASK);
		wreg(ADDR_START, 8'h01);
		repeat (20) @(posedge mclk);
		#1 chk({7'h00, act}, 8'h01);
		wreg(ADDR_CTL2, 8'h00);
		#1 chk({7'h00, act}, 8'h00);
		wreg(ADDR_START, 8'h01);
		repeat (90) @(posedge mclk);
		rchk(ADDR_CFLAG, 8'hFF);
		rchk(ADDR_ISTAT, 8'h01);
		wreg(ADDR_IMASK, 8'h01);
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, irq}, 8'h01);
		wreg(ADDR_ISTAT, 8'h01);
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, irq}, 8'h00);
		wreg(ADDR_CFLAG, 8'h01);
		rchk(ADDR_CFLAG, 8'hFE);
		wreg(ADDR_CTL2, 8'h40);
		wreg(ADDR_CMPEN, 8'h04);
		rchk(8'h11, 8'h00);
		wreg(8'h12, 8'h00);
		wreg(ADDR_CFLAG, 8'hFF);
		rchk(ADDR_CFLAG, 8'hF8);
		wreg(ADDR_TSRC, 8'h00);
		for (k = 0; k < 4; k++) begin
			trig <= {4{~k[0]}};
			wreg(ADDR_CTL2, 8'h04 | 8'(k << 3));
			repeat (4) @(posedge mclk);
			#1 chk({7'h00, act}, 8'h00);
			@(posedge mclk);
			trig <= {4{k[0]}};
			repeat (6) @(posedge mclk);
			#1 chk({7'h00, act}, 8'h01);
			wreg(ADDR_CTL2, 8'h00);
		end
		trig <= 4'h0;
		repeat (2) @(posedge mclk);
		trig <= 4'hF;
		repeat (6) @(posedge mclk);
		#1 chk({7'h00, act}, 8'h00);
		wreg(ADDR_CTL2, 8'h04);
		wreg(ADDR_TSRC, 8'h0D);
		repeat (2) @(posedge mclk);
		#1 chk(die, 8'h20);
		wreg(ADDR_TSRC, 8'h00);
		wreg(ADDR_CTL2, 8'h20);
		wreg(ADDR_START, 8'h01);
		repeat (10) @(posedge mclk);
		stop_mode <= 1'b1;
		psel      <= 5'h1F;
		for (k = 0; k < 100 && result_write !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		chk({7'h00, result_write}, 8'h01);
		rchk(ADDR_STATE, 8'h05);
		wreg(ADDR_CTL2, 8'h2C);
		trig <= 4'h0;
		repeat (2) @(posedge mclk);
		trig <= 4'hF;
		repeat (6) @(posedge mclk);
		#1 chk({7'h00, act}, 8'h00);
		@(posedge mclk);
		stop_mode <= 1'b0;
		psel      <= 5'h00;
		repeat (20) @(posedge mclk);
		wreg(ADDR_CTL2, 8'h00);
		wreg(ADDR_START, 8'h01);
		repeat (10) @(posedge mclk);
		stop_mode <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk({7'h00, act}, 8'h00);
		@(posedge mclk);
		stop_mode <= 1'b0;
		repeat (4) @(posedge mclk);
		#1 chk({7'h00, act}, 8'h01);
		hit <= 1'b1;
		repeat (80) @(posedge mclk);
		rchk(ADDR_ISTAT, 8'h03);
		#1 chk({7'h00, irq}, 8'h01);
		close_out;
	end
endmodule // tb
`default_nettype wire
